// ---- include/rrsc_pkg.sv ----
// Constants and types for the radio receive state control block
// Behaviour
// - Force-on bit keeps crystal running always
// - Osc-off and power-down strobes honoured in IDLE only
// - Crystal stops on select release, restarts on select
// - Regulator off in SLEEP, select low wakes
// - RX entered only by enter-receive strobe
// - Calibrate manually or per auto-calibration field
// - Force-idle exit from RX never calibrates
// - Setting 0x09: 3764 or 18506 cycles
// - Setting 0x0B: 4073 or 18815 cycles
// - Charge-pump field 00 gives short calibration
// - RX held until packet or carrier loss
// - After packet go IDLE or stay RX
// - Force-idle strobe reaches IDLE from anywhere
// - Timeout option aborts only if the first carrier sample lacks carrier
// - On-off keying: carrier loss valid after eight symbols
// - Carrier timeout always returns to IDLE
// - IDLE to RX takes 1953 plus calibration
// - RX to IDLE takes 2 plus calibration
// - 64-byte receive FIFO with overflow detection
// - Read header status byte carries fill level
// - Threshold is four times the field plus four
// - Threshold flag high while count at least threshold
// - Overflow flag sticky until flush
package rrsc_pkg;

  // ----------------------------------------
  // Transition and calibration counts
  // ----------------------------------------
  localparam int unsigned IDLE_TO_RX_CYCLES   = 1953;
  localparam int unsigned RX_TO_IDLE_CYCLES   = 2;
  localparam int unsigned MANUAL_CAL_PREP     = 283;
  localparam int unsigned CAL_SHORT_SET09     = 3764;
  localparam int unsigned CAL_LONG_SET09      = 18506;
  localparam int unsigned CAL_SHORT_SET0B     = 4073;
  localparam int unsigned CAL_LONG_SET0B      = 18815;
  localparam int unsigned OSC_START_CYCLES    = 16;
  localparam int unsigned TIMER_W             = 15;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [7:0] CAL_TEST_SET09       = 8'h09;
  localparam logic [1:0] CP_CAL_OFF           = 2'h0;
  localparam logic [1:0] AUTOCAL_NEVER        = 2'h0;
  localparam logic [1:0] AUTOCAL_TO_RX        = 2'h1;
  localparam logic [1:0] AUTOCAL_FROM_RX      = 2'h2;
  localparam logic [1:0] AUTOCAL_FOURTH       = 2'h3;
  localparam logic [1:0] FOURTH_COUNT_LAST    = 2'h3;
  localparam logic [1:0] RXOFF_STAY_RX        = 2'h3;
  localparam logic [3:0] OOK_VALID_SYMBOLS    = 4'h8;

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  localparam int unsigned FIFO_DEPTH          = 64;
  localparam int unsigned FIFO_AW             = 6;
  localparam int unsigned FIFO_CW             = 7;
  localparam int unsigned THR_STEP_SHIFT      = 2;
  localparam logic [3:0] STATUS_FILL_MAX      = 4'hf;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    st_sleep,
    st_osc_off,
    st_wake,
    st_idle,
    st_man_prep,
    st_cal,
    st_settle,
    st_rx,
    st_rx_end
  } rrsc_state_type;

  localparam rrsc_state_type RESET_STATE      = st_idle;

endpackage

// ---- hw/rrsc_rx_fifo.sv ----
// Receive byte FIFO with fill count and sticky overflow
`timescale 1ns/100ps
`default_nettype none
module rrsc_rx_fifo (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  // Write side
  input  wire logic                          wr_valid,
  input  wire logic [7:0]                    wr_data,
  // Read side
  input  wire logic                          rd_en,
  output logic      [7:0]                    rd_data,
  input  wire logic                          flush,
  // Status
  output logic      [rrsc_pkg::FIFO_CW-1:0]  count,
  output logic                               overflow
);

  typedef struct packed {
    logic [rrsc_pkg::FIFO_AW-1:0] wr_ptr;
    logic [rrsc_pkg::FIFO_AW-1:0] rd_ptr;
    logic [rrsc_pkg::FIFO_CW-1:0] count;
    logic                         overflow;
    logic [7:0]                   rd_data;
  } rrsc_fifo_type;

  rrsc_fifo_type r;
  rrsc_fifo_type next_r;
  logic [7:0]    mem [rrsc_pkg::FIFO_DEPTH];
  logic          do_wr;
  logic          do_rd;

  // Full FIFO drops the byte; empty read leaves pointers alone
  assign do_wr = wr_valid && (r.count != rrsc_pkg::FIFO_CW'(rrsc_pkg::FIFO_DEPTH)) && !flush;
  assign do_rd = rd_en && (r.count != '0) && !flush;

  always_comb begin
    next_r = r;
    if (do_wr) begin
      next_r.wr_ptr = r.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_r.rd_ptr  = r.rd_ptr + 1'b1;
      next_r.rd_data = mem[r.rd_ptr];
    end
    next_r.count = r.count + rrsc_pkg::FIFO_CW'(do_wr) - rrsc_pkg::FIFO_CW'(do_rd);
    if (wr_valid && !do_wr && !flush) begin
      next_r.overflow = 1'b1;
    end
    if (flush) begin
      next_r.wr_ptr   = '0;
      next_r.rd_ptr   = '0;
      next_r.count    = '0;
      next_r.overflow = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Storage kept out of reset on purpose
  always_ff @(posedge clk) begin
    if (ce && do_wr) begin
      mem[r.wr_ptr] <= wr_data;
    end
  end

  assign rd_data  = r.rd_data;
  assign count    = r.count;
  assign overflow = r.overflow;

endmodule // rrsc_rx_fifo
`default_nettype wire

// ---- hw/rrsc_radio_ctrl.sv ----
// Radio control state machine of the receiver with its receive FIFO
`timescale 1ns/100ps
`default_nettype none
module rrsc_radio_ctrl #(
  parameter int unsigned CAL_LONG_SET09 = rrsc_pkg::CAL_LONG_SET09,
  parameter int unsigned CAL_LONG_SET0B = rrsc_pkg::CAL_LONG_SET0B
) (
  // Clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  // Chip select pin
  input  wire logic                          chip_select_n,
  // Command strobes
  input  wire logic                          osc_off_strobe,
  input  wire logic                          power_down_strobe,
  input  wire logic                          enter_receive_strobe,
  input  wire logic                          manual_calibrate_strobe,
  input  wire logic                          force_idle_strobe,
  // Configuration fields
  input  wire logic                          osc_force_on,
  input  wire logic [1:0]                    auto_calibration_select,
  input  wire logic [1:0]                    receive_off_destination,
  input  wire logic                          receive_timeout_on_signal,
  input  wire logic [7:0]                    calib_test_setting,
  input  wire logic [1:0]                    charge_pump_cal_enable,
  input  wire logic [3:0]                    fifo_threshold_select,
  input  wire logic                          ook_mode,
  // Demodulator events
  input  wire logic                          packet_ok,
  input  wire logic                          carrier_sample_valid,
  input  wire logic                          carrier_sense,
  input  wire logic                          symbol_tick,
  input  wire logic                          rx_byte_valid,
  input  wire logic [7:0]                    rx_byte,
  // Host FIFO and header access
  input  wire logic                          fifo_read,
  input  wire logic                          fifo_flush,
  input  wire logic                          header_read,
  output logic      [7:0]                    fifo_data,
  output logic      [7:0]                    status_byte,
  output logic      [rrsc_pkg::FIFO_CW-1:0]  receive_byte_count,
  output logic                               fifo_threshold,
  output logic                               fifo_overflow,
  // Power and state
  output logic                               osc_enable,
  output logic                               core_reg_enable,
  output logic                               chip_ready_n,
  output logic                               calibrating,
  output logic                               rx_active,
  output logic      [3:0]                    state_code
);

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    rrsc_pkg::rrsc_state_type         state;
    logic [rrsc_pkg::TIMER_W-1:0]     timer;
    logic                             cal_to_rx;
    logic                             end_cal;
    logic [1:0]                       fourth_cnt;
    logic [3:0]                       symbols;
    logic                             first_seen;
    logic                             pend_osc_off;
    logic                             pend_sleep;
    logic [1:0]                       csn_sync;
    logic [7:0]                       status;
  } rrsc_ctrl_type;

  rrsc_ctrl_type                   r;
  rrsc_ctrl_type                   next_r;
  logic [rrsc_pkg::FIFO_CW-1:0]    fill;
  logic [rrsc_pkg::FIFO_CW-1:0]    thr_bytes;
  logic                            csn_high;
  logic                            cs_sample_ok;
  logic                            no_carrier_end;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [rrsc_pkg::TIMER_W-1:0] cal_len(
    input logic [7:0] test,
    input logic [1:0] cp
  );
    logic short_cal;
    short_cal = (cp == rrsc_pkg::CP_CAL_OFF);
    if (test == rrsc_pkg::CAL_TEST_SET09) begin
      cal_len = short_cal ? rrsc_pkg::TIMER_W'(rrsc_pkg::CAL_SHORT_SET09)
                          : rrsc_pkg::TIMER_W'(CAL_LONG_SET09);
    end else begin
      cal_len = short_cal ? rrsc_pkg::TIMER_W'(rrsc_pkg::CAL_SHORT_SET0B)
                          : rrsc_pkg::TIMER_W'(CAL_LONG_SET0B);
    end
  endfunction

  // Calibration after an automatic RX exit
  function automatic logic cal_after_rx(
    input logic [1:0] sel,
    input logic [1:0] cnt
  );
    cal_after_rx = (sel == rrsc_pkg::AUTOCAL_FROM_RX) ||
                   ((sel == rrsc_pkg::AUTOCAL_FOURTH) && (cnt == rrsc_pkg::FOURTH_COUNT_LAST));
  endfunction

  // Pin synchroniser: only the second stage is read
  assign csn_high = r.csn_sync[1];

  // Carrier samples count only after eight symbols under on-off keying
  assign cs_sample_ok = carrier_sample_valid &&
                        (!ook_mode || (r.symbols == rrsc_pkg::OOK_VALID_SYMBOLS));
  assign no_carrier_end = receive_timeout_on_signal && cs_sample_ok &&
                          !r.first_seen && !carrier_sense;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r             = r;
    next_r.csn_sync    = {r.csn_sync[0], chip_select_n};
    next_r.timer       = (r.timer > 1) ? r.timer - 1'b1 : r.timer;
    next_r.status      = header_read ? {chip_ready_n, state_code[2:0],
                         (fill > rrsc_pkg::FIFO_CW'(rrsc_pkg::STATUS_FILL_MAX)) ?
                         rrsc_pkg::STATUS_FILL_MAX : fill[3:0]} : r.status;

    case (r.state)
      rrsc_pkg::st_sleep, rrsc_pkg::st_osc_off: begin
        if (!csn_high) begin
          next_r.state = rrsc_pkg::st_wake;
          next_r.timer = rrsc_pkg::TIMER_W'(rrsc_pkg::OSC_START_CYCLES);
        end
      end
      rrsc_pkg::st_wake: begin
        if (r.timer == 1) begin
          next_r.state = rrsc_pkg::st_idle;
        end
      end
      rrsc_pkg::st_idle: begin
        if (osc_off_strobe) begin
          next_r.pend_osc_off = 1'b1;
        end else if (power_down_strobe) begin
          next_r.pend_sleep = 1'b1;
        end
        if (csn_high && r.pend_sleep) begin
          next_r.state      = rrsc_pkg::st_sleep;
          next_r.pend_sleep = 1'b0;
        end else if (csn_high && r.pend_osc_off) begin
          next_r.state        = rrsc_pkg::st_osc_off;
          next_r.pend_osc_off = 1'b0;
        end else if (enter_receive_strobe) begin
          next_r.pend_osc_off = 1'b0;
          next_r.pend_sleep   = 1'b0;
          if (auto_calibration_select == rrsc_pkg::AUTOCAL_TO_RX) begin
            next_r.state     = rrsc_pkg::st_cal;
            next_r.cal_to_rx = 1'b1;
            next_r.timer     = cal_len(calib_test_setting, charge_pump_cal_enable);
          end else begin
            next_r.state = rrsc_pkg::st_settle;
            next_r.timer = rrsc_pkg::TIMER_W'(rrsc_pkg::IDLE_TO_RX_CYCLES);
          end
        end else if (manual_calibrate_strobe) begin
          next_r.state     = rrsc_pkg::st_man_prep;
          next_r.cal_to_rx = 1'b0;
          next_r.timer     = rrsc_pkg::TIMER_W'(rrsc_pkg::MANUAL_CAL_PREP);
        end
      end
      rrsc_pkg::st_man_prep: begin
        if (r.timer == 1) begin
          next_r.state = rrsc_pkg::st_cal;
          next_r.timer = cal_len(calib_test_setting, charge_pump_cal_enable);
        end
      end
      rrsc_pkg::st_cal: begin
        if (r.timer == 1) begin
          if (r.cal_to_rx) begin
            next_r.state = rrsc_pkg::st_settle;
            next_r.timer = rrsc_pkg::TIMER_W'(rrsc_pkg::IDLE_TO_RX_CYCLES);
          end else begin
            next_r.state = rrsc_pkg::st_idle;
          end
          next_r.cal_to_rx = 1'b0;
        end
      end
      rrsc_pkg::st_settle: begin
        if (r.timer == 1) begin
          next_r.state      = rrsc_pkg::st_rx;
          next_r.first_seen = 1'b0;
          next_r.symbols    = '0;
        end
      end
      rrsc_pkg::st_rx: begin
        if (symbol_tick && (r.symbols != rrsc_pkg::OOK_VALID_SYMBOLS)) begin
          next_r.symbols = r.symbols + 1'b1;
        end
        if (cs_sample_ok) begin
          next_r.first_seen = 1'b1;
        end
        // Carrier timeout wins over a packet in the same cycle
        if (no_carrier_end || (packet_ok && receive_off_destination != rrsc_pkg::RXOFF_STAY_RX)) begin
          next_r.state   = rrsc_pkg::st_rx_end;
          next_r.timer   = rrsc_pkg::TIMER_W'(rrsc_pkg::RX_TO_IDLE_CYCLES);
          next_r.end_cal = cal_after_rx(auto_calibration_select, r.fourth_cnt);
          if (auto_calibration_select == rrsc_pkg::AUTOCAL_FOURTH) begin
            next_r.fourth_cnt = r.fourth_cnt + 1'b1;
          end
        end else if (packet_ok) begin
          next_r.first_seen = 1'b0;
          next_r.symbols    = '0;
        end
      end
      rrsc_pkg::st_rx_end: begin
        if (r.timer == 1) begin
          if (r.end_cal) begin
            next_r.state     = rrsc_pkg::st_cal;
            next_r.cal_to_rx = 1'b0;
            next_r.timer     = cal_len(calib_test_setting, charge_pump_cal_enable);
          end else begin
            next_r.state = rrsc_pkg::st_idle;
          end
          next_r.end_cal = 1'b0;
        end
      end
      default: begin
        next_r.state = rrsc_pkg::st_idle;
      end
    endcase

    // Force-idle overrides everything, with no calibration
    if (force_idle_strobe) begin
      next_r.state        = rrsc_pkg::st_idle;
      next_r.end_cal      = 1'b0;
      next_r.cal_to_rx    = 1'b0;
      next_r.pend_osc_off = 1'b0;
      next_r.pend_sleep   = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r              <= '0;
      r.state        <= rrsc_pkg::RESET_STATE;
      r.csn_sync     <= 2'h3;
      r.status       <= 8'h00;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  rrsc_rx_fifo u_fifo (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .wr_valid (rx_byte_valid),
    .wr_data  (rx_byte),
    .rd_en    (fifo_read),
    .rd_data  (fifo_data),
    .flush    (fifo_flush),
    .count    (fill),
    .overflow (fifo_overflow)
  );

  assign thr_bytes          = rrsc_pkg::FIFO_CW'({3'h0, fifo_threshold_select} + 7'h01) << rrsc_pkg::THR_STEP_SHIFT;
  assign fifo_threshold     = (fill >= thr_bytes);
  assign receive_byte_count = fill;

  // ----------------------------------------
  // Power and state outputs
  // ----------------------------------------
  // Forced oscillator ignores every state, sleep included
  assign osc_enable      = osc_force_on ||
                           !((r.state == rrsc_pkg::st_sleep) || (r.state == rrsc_pkg::st_osc_off));
  assign core_reg_enable = (r.state != rrsc_pkg::st_sleep);
  assign chip_ready_n    = (r.state == rrsc_pkg::st_sleep) || (r.state == rrsc_pkg::st_osc_off) ||
                           (r.state == rrsc_pkg::st_wake);
  assign calibrating     = (r.state == rrsc_pkg::st_cal);
  assign rx_active       = (r.state == rrsc_pkg::st_rx);
  assign state_code      = r.state;
  assign status_byte     = r.status;

endmodule // rrsc_radio_ctrl
`default_nettype wire

// ---- testbench/rrsc_ctrl_sva.sv ----
// Port checker for the radio receive state control block
`timescale 1ns/100ps
`default_nettype none
module rrsc_ctrl_sva (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         srst,
  // Inputs watched
  input wire logic                         force_idle_strobe,
  input wire logic                         osc_force_on,
  input wire logic [3:0]                   fifo_threshold_select,
  input wire logic                         fifo_flush,
  input wire logic                         header_read,
  // Outputs watched
  input wire logic [7:0]                   status_byte,
  input wire logic [rrsc_pkg::FIFO_CW-1:0] receive_byte_count,
  input wire logic                         fifo_threshold,
  input wire logic                         fifo_overflow,
  input wire logic                         osc_enable,
  input wire logic                         core_reg_enable,
  input wire logic                         rx_active,
  input wire logic [3:0]                   state_code
);
  logic [10:0] settle_cnt;
  logic [3:0]  fill_clip;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Cycles spent in settle, so the exit can be tied to the exact figure
  always_ff @(posedge clk) begin
    if (srst || state_code != 4'h6) begin
      settle_cnt <= 11'h0;
    end else begin
      settle_cnt <= settle_cnt + 11'h1;
    end
  end
  assign fill_clip = (receive_byte_count > 7'hf) ? 4'hf : receive_byte_count[3:0];

  a_thr_flag_level: assert property (fifo_threshold == (receive_byte_count >= (({3'h0, fifo_threshold_select} + 7'h1) << 2))) else $error("threshold flag wrong");
  a_fill_in_range: assert property (receive_byte_count <= 7'h40) else $error("fill count beyond depth");
  a_ovf_held: assert property (fifo_overflow && !fifo_flush |=> fifo_overflow) else $error("overflow dropped");
  a_rx_via_settle: assert property ($rose(rx_active) |-> $past(state_code) == 4'h6) else $error("rx without settle");
  a_settle_count: assert property (state_code == 4'h7 && $past(state_code) == 4'h6 |-> settle_cnt == 11'h7a1) else $error("settle length wrong");
  a_force_to_idle: assert property (force_idle_strobe |=> state_code == 4'h3) else $error("force idle ignored");
  a_exit_two: assert property (state_code == 4'h8 && $past(state_code) == 4'h7 |-> ##2 (state_code == 4'h3 || state_code == 4'h5)) else $error("rx exit length wrong");
  a_status_fill: assert property (header_read |=> status_byte[3:0] == $past(fill_clip)) else $error("status fill wrong");
  a_sleep_power_off: assert property (state_code == 4'h0 |-> !core_reg_enable) else $error("regulator on in sleep");
  a_osc_stop_state: assert property (state_code inside {4'h0, 4'h1} |-> osc_enable == osc_force_on) else $error("crystal state wrong");
endmodule // rrsc_ctrl_sva

bind rrsc_radio_ctrl rrsc_ctrl_sva u_rrsc_ctrl_sva (.clk, .srst, .force_idle_strobe, .osc_force_on,
  .fifo_threshold_select, .fifo_flush, .header_read, .status_byte, .receive_byte_count, .fifo_threshold,
  .fifo_overflow, .osc_enable, .core_reg_enable, .rx_active, .state_code);
`default_nettype wire

// ---- testbench/rrsc_host_model.sv ----
// Host model that drains the receive FIFO
`timescale 1ns/100ps
`default_nettype none
module rrsc_host_model (
  // Clock and control
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         drain,
  // FIFO side
  input  wire logic [rrsc_pkg::FIFO_CW-1:0] receive_byte_count,
  input  wire logic [7:0]                   fifo_data,
  output logic                              fifo_read
);
  logic [7:0] seen [$];
  logic       rd_d;

  initial begin
    fifo_read = 1'b0;
    rd_d = 1'b0;
  end
  // Pops every other cycle so the count looked at is already settled
  always @(negedge clk) begin
    if (rd_d) begin
      seen.push_back(fifo_data);
    end
    rd_d = fifo_read;
    fifo_read = drain && !srst && !fifo_read && receive_byte_count != 7'h0;
  end
endmodule // rrsc_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the radio receive state control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk, srst, ce, chip_select_n, osc_force_on, receive_timeout_on_signal, ook_mode;
  logic       osc_off_strobe, power_down_strobe, enter_receive_strobe, manual_calibrate_strobe, force_idle_strobe;
  logic [1:0] auto_calibration_select, receive_off_destination, charge_pump_cal_enable;
  logic [7:0] calib_test_setting, rx_byte, fifo_data, status_byte;
  logic [3:0] fifo_threshold_select, state_code;
  logic       packet_ok, carrier_sample_valid, carrier_sense, symbol_tick, rx_byte_valid;
  logic       fifo_read, fifo_flush, header_read, drain, fifo_threshold, fifo_overflow;
  logic       osc_enable, core_reg_enable, chip_ready_n, calibrating, rx_active;
  logic [rrsc_pkg::FIFO_CW-1:0] receive_byte_count;
  int         n_mismatch, tests_run, n;

  rrsc_radio_ctrl #(.CAL_LONG_SET09(40), .CAL_LONG_SET0B(50)) u_rrsc_radio_ctrl (.clk, .srst, .ce, .chip_select_n,
    .osc_off_strobe, .power_down_strobe, .enter_receive_strobe, .manual_calibrate_strobe, .force_idle_strobe,
    .osc_force_on, .auto_calibration_select, .receive_off_destination, .receive_timeout_on_signal,
    .calib_test_setting, .charge_pump_cal_enable, .fifo_threshold_select, .ook_mode, .packet_ok,
    .carrier_sample_valid, .carrier_sense, .symbol_tick, .rx_byte_valid, .rx_byte, .fifo_read, .fifo_flush,
    .header_read, .fifo_data, .status_byte, .receive_byte_count, .fifo_threshold, .fifo_overflow, .osc_enable,
    .core_reg_enable, .chip_ready_n, .calibrating, .rx_active, .state_code);
  rrsc_host_model u_rrsc_host_model (.clk, .srst, .drain, .receive_byte_count, .fifo_data, .fifo_read);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wait_code(input logic [3:0] code);
    n = 0;
    while (state_code !== code && n < 30000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_rx;
    chk({state_code, osc_enable, core_reg_enable, chip_ready_n, fifo_overflow}, 8'h3c);
    pulse(enter_receive_strobe);
    chk(state_code, 4'h6);
    wait_code(4'h7);
    chk(n, 1953);
    pulse(osc_off_strobe);
    pulse(manual_calibrate_strobe);
    receive_off_destination = 2'h3;
    pulse(packet_ok);
    chk(state_code, 4'h7);
    receive_off_destination = 2'h0;
    pulse(packet_ok);
    chk(state_code, 4'h8);
    wait_code(4'h3);
    chk(n, 2);
  endtask
  task automatic t_cal;
    logic [7:0] tst [4] = '{8'h09, 8'h09, 8'h0b, 8'h5a};
    logic [1:0] cp [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
    int         len [4] = '{3764, 40, 4073, 50};
    for (int i = 0; i < 4; i++) begin
      calib_test_setting = tst[i];
      charge_pump_cal_enable = cp[i];
      pulse(manual_calibrate_strobe);
      wait_code(4'h5);
      chk(n, 283);
      wait_code(4'h3);
      chk(n, len[i]);
    end
  endtask
  task automatic t_auto;
    calib_test_setting = 8'h09;
    charge_pump_cal_enable = 2'h0;
    auto_calibration_select = 2'h1;
    pulse(enter_receive_strobe);
    wait_code(4'h6);
    chk(n, 3764);
    wait_code(4'h7);
    chk(n, 1953);
    auto_calibration_select = 2'h2;
    pulse(force_idle_strobe);
    repeat (4) @(negedge clk);
    chk(state_code, 4'h3);
    pulse(enter_receive_strobe);
    wait_code(4'h7);
    receive_off_destination = 2'h3;
    receive_timeout_on_signal = 1'b1;
    carrier_sense = 1'b1;
    pulse(carrier_sample_valid);
    carrier_sense = 1'b0;
    pulse(carrier_sample_valid);
    chk(state_code, 4'h7);
    pulse(packet_ok);
    pulse(carrier_sample_valid);
    chk(state_code, 4'h8);
    wait_code(4'h3);
    chk(n, 3766);
    receive_timeout_on_signal = 1'b0;
    receive_off_destination = 2'h0;
    auto_calibration_select = 2'h3;
    for (int i = 1; i <= 4; i++) begin
      pulse(enter_receive_strobe);
      wait_code(4'h7);
      pulse(packet_ok);
      repeat (2) @(negedge clk);
      chk({state_code, calibrating}, (i == 4) ? 5'h0b : 5'h06);
      wait_code(4'h3);
    end
    auto_calibration_select = 2'h0;
  endtask
  task automatic t_ook;
    ook_mode = 1'b1;
    receive_timeout_on_signal = 1'b1;
    pulse(enter_receive_strobe);
    wait_code(4'h7);
    for (int i = 0; i < 8; i++) begin
      pulse(carrier_sample_valid);
      chk(state_code, 4'h7);
      pulse(symbol_tick);
    end
    pulse(carrier_sample_valid);
    chk(state_code, 4'h8);
    wait_code(4'h3);
    ook_mode = 1'b0;
    receive_timeout_on_signal = 1'b0;
  endtask
  task automatic t_power;
    for (int f = 0; f < 2; f++) begin
      osc_force_on = f[0];
      chip_select_n = 1'b0;
      pulse(power_down_strobe);
      repeat (4) @(negedge clk);
      chk(state_code, 4'h3);
      chip_select_n = 1'b1;
      wait_code(4'h0);
      chk({core_reg_enable, osc_enable}, {1'b0, f[0]});
      chip_select_n = 1'b0;
      wait_code(4'h3);
      chk({core_reg_enable, osc_enable, chip_ready_n}, 3'h6);
      pulse(osc_off_strobe);
      chip_select_n = 1'b1;
      wait_code(4'h1);
      chk(osc_enable, f[0]);
      chip_select_n = 1'b0;
      wait_code(4'h3);
    end
    osc_force_on = 1'b0;
  endtask
  task automatic t_fifo;
    for (int k = 1; k <= 65; k++) begin
      rx_byte = k[7:0];
      pulse(rx_byte_valid);
      for (int s = 0; s < 16; s++) begin
        fifo_threshold_select = s[3:0];
        #0.5;
        chk(fifo_threshold, ((k > 64) ? 64 : k) >= 4 * (s + 1));
      end
    end
    chk({receive_byte_count, fifo_overflow}, 8'h81);
    pulse(header_read);
    chk(status_byte, 8'h3f);
    drain = 1'b1;
    n = 0;
    while (receive_byte_count !== 7'h0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    drain = 1'b0;
    chk(u_rrsc_host_model.seen.size(), 64);
    for (int i = 0; i < u_rrsc_host_model.seen.size(); i++) begin
      chk(u_rrsc_host_model.seen[i], i + 1);
    end
    pulse(header_read);
    chk({status_byte[3:0], fifo_overflow}, 5'h01);
    pulse(fifo_flush);
    chk(fifo_overflow, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    {osc_off_strobe, power_down_strobe, enter_receive_strobe, manual_calibrate_strobe, force_idle_strobe} = '0;
    {osc_force_on, receive_timeout_on_signal, ook_mode, auto_calibration_select, receive_off_destination} = '0;
    {charge_pump_cal_enable, calib_test_setting, rx_byte, fifo_threshold_select} = '0;
    {packet_ok, carrier_sample_valid, carrier_sense, symbol_tick, rx_byte_valid} = '0;
    {fifo_flush, header_read, drain, n_mismatch, tests_run} = '0;
    {srst, ce, chip_select_n} = 3'h7;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_rx;
    t_cal;
    t_auto;
    t_ook;
    t_power;
    t_fifo;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
